// ---- hdl/bsctp_defines.svh ----
// Purpose: constants for the boundary-scan test port
// Assumes: 4-bit instruction register, 32-bit identification register
// Notes:   identification value is arbitrary
`ifndef BSCTP_DEFINES_SVH
`define BSCTP_DEFINES_SVH
`define BSCTP_IR_WIDTH      4
`define BSCTP_ID_WIDTH      32
`define BSCTP_IR_CAPTURE    4'h1
`define BSCTP_INSN_IDCODE   4'h2
`define BSCTP_INSN_BYPASS   4'hf
`define BSCTP_ID_VALUE      32'h0000_0001
`define BSCTP_RESET_TMS_CNT 5
// idle pin levels {TRST_N, TDI, TMS, TCK}: pulled-up pins high, TCK low
`define BSCTP_PIN_IDLE      4'he
`endif

// ---- hdl/bsctp_pkg.sv ----
// Purpose: types for the boundary-scan test port
// Assumes: nothing
// Notes:   one-hot state codes
package bsctp_pkg;
  typedef enum logic [15:0] {
    ST_RESET  = 16'h0001,
    ST_IDLE   = 16'h0002,
    ST_SELDR  = 16'h0004,
    ST_CAPDR  = 16'h0008,
    ST_SHDR   = 16'h0010,
    ST_EX1DR  = 16'h0020,
    ST_PAUSDR = 16'h0040,
    ST_EX2DR  = 16'h0080,
    ST_UPDR   = 16'h0100,
    ST_SELIR  = 16'h0200,
    ST_CAPIR  = 16'h0400,
    ST_SHIR   = 16'h0800,
    ST_EX1IR  = 16'h1000,
    ST_PAUSIR = 16'h2000,
    ST_EX2IR  = 16'h4000,
    ST_UPIR   = 16'h8000
  } bsctp_state_t;
endpackage

// ---- hdl/bsctp_port.sv ----
// Purpose: boundary-scan test access port, sampled on MCLK
// Assumes: TCK slow against MCLK; pull-ups modelled as inputs read high when floating
// Notes:   controller does not reset at power-up; FIFO output gate follows
`timescale 1ns/10ps
`default_nettype none
`include "bsctp_defines.svh"

// Notes on behaviour
// - TMS and TDI captured on rising TCK; all test logic but test reset synchronous to TCK.
// - test outputs, TDO included, change only on falling TCK, except TDO_OE, which test reset drops at once.
// - TDI shifts on rising TCK into selected instruction, identification or bypass register.
// - TDO shifts out the selected register on falling TCK.
// - TDO driven only in SHIFT-DR or SHIFT-IR, otherwise released.
// - TMS steers the controller through its states.
// - test reset input resets the controller without any TCK edge.
// - no power-up reset; reset by test reset or five TCKs of TMS high.
// - FIFO data outputs stay released until the controller has been reset.
// - TDI, TMS and test reset read high when unconnected.
module bsctp_port
  import bsctp_pkg::*;
(
  // clock and reset
  input  wire logic MCLK,
  input  wire logic RESETN,
  // scan pins
  input  wire logic TCK,
  input  wire logic TMS,
  input  wire logic TDI,
  input  wire logic TRST_N,
  output logic      TDO,
  output logic      TDO_OE,
  // fifo output gate
  output logic      FIFO_OUT_ENABLE
);

  // two-flop synchronisers, one per pin; first stage read only by second
  // reset to idle pin levels, else a false test reset follows RESETN
  localparam logic [3:0] pin_idle = `BSCTP_PIN_IDLE;
  logic [3:0] pins;
  logic [3:0] sync;
  logic       tck_d;

  assign pins = {TRST_N, TDI, TMS, TCK};

  for (genvar gi = 0; gi < 4; gi++) begin : g_sync
    logic meta;
    logic hold;
    always_ff @(posedge MCLK) begin
      if (!RESETN) begin
        meta <= pin_idle[gi];
        hold <= pin_idle[gi];
      end else begin
        meta <= pins[gi];
        hold <= meta;
      end
    end
    assign sync[gi] = hold;
  end

  // edge flop after the second stage
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      tck_d <= 1'b0;
    end else begin
      tck_d <= sync[0];
    end
  end

  // tck phases under two MCLK periods may be missed;
  // every pin is seen two MCLK late, and TDO, registered once more, lags by three

  logic tck_rise;
  logic tck_fall;
  logic tms_s;
  logic tdi_s;
  logic trst_act;
  assign tck_rise = sync[0] & ~tck_d;
  assign tck_fall = ~sync[0] & tck_d;
  // unconnected pins float high, so these read as 1
  assign tms_s    = sync[1];
  assign tdi_s    = sync[2];
  // reset acts at once, no tck edge needed; RESETN is power-up only
  assign trst_act = ~sync[3];

  // controller state; power-up leaves it unreset
  bsctp_state_t state;
  bsctp_state_t next_state;
  logic         been_reset;

  always_comb begin
    case (state)
      ST_RESET:  next_state = tms_s ? ST_RESET  : ST_IDLE;
      ST_IDLE:   next_state = tms_s ? ST_SELDR  : ST_IDLE;
      ST_SELDR:  next_state = tms_s ? ST_SELIR  : ST_CAPDR;
      ST_CAPDR:  next_state = tms_s ? ST_EX1DR  : ST_SHDR;
      ST_SHDR:   next_state = tms_s ? ST_EX1DR  : ST_SHDR;
      ST_EX1DR:  next_state = tms_s ? ST_UPDR   : ST_PAUSDR;
      ST_PAUSDR: next_state = tms_s ? ST_EX2DR  : ST_PAUSDR;
      ST_EX2DR:  next_state = tms_s ? ST_UPDR   : ST_SHDR;
      ST_UPDR:   next_state = tms_s ? ST_SELDR  : ST_IDLE;
      ST_SELIR:  next_state = tms_s ? ST_RESET  : ST_CAPIR;
      ST_CAPIR:  next_state = tms_s ? ST_EX1IR  : ST_SHIR;
      ST_SHIR:   next_state = tms_s ? ST_EX1IR  : ST_SHIR;
      ST_EX1IR:  next_state = tms_s ? ST_UPIR   : ST_PAUSIR;
      ST_PAUSIR: next_state = tms_s ? ST_EX2IR  : ST_PAUSIR;
      ST_EX2IR:  next_state = tms_s ? ST_UPIR   : ST_SHIR;
      ST_UPIR:   next_state = tms_s ? ST_SELDR  : ST_IDLE;
      default:   next_state = ST_RESET;
    endcase
  end

  // five tck with tms high always reach ST_RESET from any state
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      state <= ST_IDLE;
    end else if (trst_act) begin
      state <= ST_RESET;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  // fifo outputs released until the controller has seen a reset
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      been_reset <= 1'b0;
    end else if (trst_act || state == ST_RESET) begin
      been_reset <= 1'b1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      FIFO_OUT_ENABLE <= 1'b0;
    end else begin
      FIFO_OUT_ENABLE <= been_reset;
    end
  end

  // instruction register and shadow
  logic [`BSCTP_IR_WIDTH-1:0] ir_shift;
  logic [`BSCTP_IR_WIDTH-1:0] ir;
  logic [`BSCTP_ID_WIDTH-1:0] id_shift;
  logic                       byp;
  logic                       sel_id;

  assign sel_id = (ir == `BSCTP_INSN_IDCODE);

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      ir_shift <= `BSCTP_IR_CAPTURE;
    end else if (tck_rise) begin
      if (state == ST_CAPIR) begin
        ir_shift <= `BSCTP_IR_CAPTURE;
      end else if (state == ST_SHIR) begin
        ir_shift <= {tdi_s, ir_shift[`BSCTP_IR_WIDTH-1:1]};
      end
    end
  end

  // update on falling tck keeps the old instruction for the whole scan
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      ir <= `BSCTP_INSN_IDCODE;
    end else if (trst_act || state == ST_RESET) begin
      ir <= `BSCTP_INSN_IDCODE;
    end else if (tck_fall && state == ST_UPIR) begin
      ir <= ir_shift;
    end
  end

  // data registers: identification or bypass, others fall to bypass
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      id_shift <= `BSCTP_ID_VALUE;
      byp      <= 1'b0;
    end else if (tck_rise) begin
      if (state == ST_CAPDR) begin
        id_shift <= `BSCTP_ID_VALUE;
        byp      <= 1'b0;
      end else if (state == ST_SHDR) begin
        if (sel_id) begin
          id_shift <= {tdi_s, id_shift[`BSCTP_ID_WIDTH-1:1]};
        end else begin
          byp <= tdi_s;
        end
      end
    end
  end

  // what the next tck fall puts on the pin
  logic next_tdo;
  logic next_tdo_oe;

  always_comb begin
    next_tdo_oe = (state == ST_SHDR) || (state == ST_SHIR);
    if (state == ST_SHIR) begin
      next_tdo = ir_shift[0];
    end else if (sel_id) begin
      next_tdo = id_shift[0];
    end else begin
      next_tdo = byp;
    end
  end

  // tdo moves only on falling tck; its enable also drops at once on test reset
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      TDO    <= 1'b0;
      TDO_OE <= 1'b0;
    end else if (trst_act) begin
      TDO_OE <= 1'b0;
    end else if (tck_fall) begin
      TDO_OE <= next_tdo_oe;
      TDO    <= next_tdo;
    end
  end

endmodule
`default_nettype wire

// ---- tb/bsctp_port_asserts.sv ----
// Purpose: pin-level checks of the scan port
// Assumes: TCK phases of 4 MCLK
// Notes: edge checks allow one MCLK of slack
`timescale 1ns/10ps
`default_nettype none
module bsctp_port_chk (
  input wire logic MCLK, RESETN, TCK, TMS, TDI, TRST_N, TDO, TDO_OE, FIFO_OUT_ENABLE
);
  logic       tck_q;
  logic [2:0] cnt;
  logic       seen;
  always_ff @(posedge MCLK) begin
    tck_q <= TCK;
    if (!RESETN) cnt <= 3'h0;
    else if (TCK && !tck_q) cnt <= TMS ? ((cnt == 3'h5) ? cnt : cnt + 3'h1) : 3'h0;
  end
  // three ones from idle already reach reset
  always_ff @(posedge MCLK) begin
    if (!RESETN) seen <= 1'b0;
    else if (!TRST_N || cnt >= 3'h3) seen <= 1'b1;
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  sequence tck_fell;
    !$past(TCK) && ($past(TCK, 3) || $past(TCK, 4) || $past(TCK, 5));
  endsequence
  sequence five_high;
    (cnt == 3'h4) ##1 (cnt == 3'h5);
  endsequence
  tdo_on_fall_a: assert property ($changed(TDO) && $past(TRST_N, 3) |-> tck_fell)
    else $error("TDO moved off a TCK fall");
  oe_rise_a: assert property ($rose(TDO_OE) |-> tck_fell)
    else $error("TDO_OE rose off a TCK fall");
  oe_drop_a: assert property ($fell(TDO_OE) && $past(TRST_N, 2) && $past(TRST_N, 3) |-> tck_fell)
    else $error("TDO_OE fell off a TCK fall");
  trst_async_a: assert property ($fell(TRST_N) |-> ##[1:6] (!TDO_OE && FIFO_OUT_ENABLE))
    else $error("test reset ignored");
  trst_hold_a: assert property (!TRST_N [*6] |-> !TDO_OE && FIFO_OUT_ENABLE)
    else $error("held test reset not obeyed");
  foe_sticky_a: assert property (FIFO_OUT_ENABLE |=> FIFO_OUT_ENABLE)
    else $error("output gate dropped");
  foe_cause_a: assert property (FIFO_OUT_ENABLE |-> seen)
    else $error("output gate without port reset");
  tms_reset_a: assert property (five_high |-> ##[0:8] FIFO_OUT_ENABLE)
    else $error("five TMS ones did not reset");
endmodule
`default_nettype wire

// ---- tb/bsctp_tester.sv ----
// Purpose: scan tester driving the port pins
// Assumes: 160 ns TCK, still low between frames
// Notes: released TDO reads as inverse of last bit
`timescale 1ns/10ps
`default_nettype none
module bsctp_tester (
  input wire logic MCLK, TDO, TDO_OE,
  output logic     TCK, TMS, TDI, TRST_N
);
  logic last;
  initial begin
    TCK = 1'b0;
    TMS = 1'b1;
    TDI = 1'b1;
    TRST_N = 1'b1;
    last = 1'b0;
  end
  task automatic hold_reset(input logic v);
    TRST_N = v;
  endtask
  task automatic tick(input logic m, input logic d, output logic q);
    TMS = m;
    TDI = d;
    repeat (4) @(negedge MCLK);
    TCK = 1'b1;
    q = TDO_OE ? TDO : ~last;
    last = q;
    repeat (4) @(negedge MCLK);
    TCK = 1'b0;
  endtask
  task automatic walk(input logic [31:0] m, d, input int n, output logic [31:0] q);
    q = 32'h0;
    for (int i = 0; i < n; i++) tick(m[i], d[i], q[i]);
  endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Purpose: self-checking bench of the scan port
// Assumes: tester model on the pins
// Notes: IR table rows, then resets
`timescale 1ns/10ps
`default_nettype none
`include "bsctp_defines.svh"
module tb;
  typedef struct { logic [3:0] ir; logic [31:0] dr; } bsctp_row_t;
  localparam logic [31:0] PAT = 32'ha5c3_0f96;
  logic MCLK, RESETN, TCK, TMS, TDI, TRST_N, TDO, TDO_OE, FIFO_OUT_ENABLE;
  logic [31:0] q;
  int n_fail = 0;
  int checks = 0;
  bsctp_row_t rows [3] = '{'{4'h2, `BSCTP_ID_VALUE}, '{4'hf, {PAT[30:0], 1'b0}}, '{4'h6, {PAT[30:0], 1'b0}}};
  bsctp_port DUT (.MCLK(MCLK), .RESETN(RESETN), .TCK(TCK), .TMS(TMS), .TDI(TDI), .TRST_N(TRST_N),
                  .TDO(TDO), .TDO_OE(TDO_OE), .FIFO_OUT_ENABLE(FIFO_OUT_ENABLE));
  bsctp_tester u_tst (.MCLK(MCLK), .TDO(TDO), .TDO_OE(TDO_OE), .TCK(TCK), .TMS(TMS), .TDI(TDI), .TRST_N(TRST_N));
  task automatic chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic sys_reset;
    RESETN = 1'b0;
    repeat (2) @(negedge MCLK);
    RESETN = 1'b1;
    repeat (4) @(negedge MCLK);
  endtask
  initial begin
    MCLK = 1'b0;
    forever #10 MCLK = ~MCLK;
  end
  initial begin
    #200000;
    n_fail++;
    finish_test;
  end
  initial begin
    sys_reset();
    chk({31'h0, FIFO_OUT_ENABLE}, 32'h0);
    chk({31'h0, TDO_OE}, 32'h0);
    u_tst.walk(32'h1f, 32'h0, 5, q);
    repeat (4) @(negedge MCLK);
    chk({31'h0, FIFO_OUT_ENABLE}, 32'h1);
    u_tst.walk(32'h0, 32'h0, 1, q);
    foreach (rows[i]) begin
      u_tst.walk(32'h3, 32'h0, 4, q);
      u_tst.walk(32'h8, {28'h0, rows[i].ir}, 4, q);
      chk(q, {28'h0, `BSCTP_IR_CAPTURE});
      u_tst.walk(32'h3, 32'h0, 4, q);
      u_tst.walk(32'h8000_0000, PAT, 32, q);
      chk(q, rows[i].dr);
      u_tst.walk(32'h1, 32'h0, 2, q);
    end
    // bypass bit kept through pause-DR and exit2-DR
    u_tst.walk(32'ha9, 32'h08, 8, q);
    chk({30'h0, q[7], q[3]}, 32'h2);
    u_tst.walk(32'h1, 32'h0, 2, q);
    sys_reset();
    chk({31'h0, FIFO_OUT_ENABLE}, 32'h0);
    u_tst.walk(32'h1, 32'h0, 3, q);
    repeat (4) @(negedge MCLK);
    chk({31'h0, TDO_OE}, 32'h1);
    u_tst.hold_reset(1'b0);
    repeat (8) @(negedge MCLK);
    chk({31'h0, TDO_OE}, 32'h0);
    chk({31'h0, FIFO_OUT_ENABLE}, 32'h1);
    u_tst.hold_reset(1'b1);
    // five TMS ones from shift-DR, far from idle
    sys_reset();
    u_tst.walk(32'h1, 32'h0, 3, q);
    chk({31'h0, FIFO_OUT_ENABLE}, 32'h0);
    u_tst.walk(32'h1f, 32'h0, 5, q);
    repeat (4) @(negedge MCLK);
    chk({31'h0, FIFO_OUT_ENABLE}, 32'h1);
    chk({31'h0, TDO_OE}, 32'h0);
    finish_test();
  end
endmodule
bind bsctp_port bsctp_port_chk u_chk (.MCLK(MCLK), .RESETN(RESETN), .TCK(TCK), .TMS(TMS), .TDI(TDI),
  .TRST_N(TRST_N), .TDO(TDO), .TDO_OE(TDO_OE), .FIFO_OUT_ENABLE(FIFO_OUT_ENABLE));
`default_nettype wire
